// [bench/ldm_display_ctrl_bench.sv]
// Self-checking bench for the display and menu controller.
// Assumes shortened timeouts: 200 cycles simulation, 100 cycles menu idle.
`timescale 1ns/100ps
module ldm_display_ctrl_bench;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_sys = 1'b0, reset_n = 1'b0;
  logic [3:0]  key_raw, magnet_raw, cfg_damping1 = 4'hB, cfg_damping2 = 4'h0;
  logic        store_done, store_req, cfg_backlight_en = 1'b1;
  logic        cfg_temp_fahrenheit = 1'b1, cfg_alarm_high = 1'b0;
  logic        cfg_set_4ma_point = 1'b0, cfg_set_20ma_point = 1'b0;
  logic [15:0] measured_ua = 16'h2EE0, upper_float_level = 16'h0100;
  logic [15:0] lower_float_level = 16'h0080, temperature_value = 16'h0019;
  logic [15:0] float_position = 16'h03E8, cfg_sim_low_ua = 16'h1F40;
  logic [15:0] cfg_sim_high_ua = 16'h3A98, loop_ua, point_4ma, point_20ma;
  logic [15:0] min_upper, max_upper, min_lower, max_lower, min_temp, max_temp;
  logic [31:0] cfg_sim_cycle = 32'h00000009;
  logic [5:0]  error_flags = 6'h00;
  logic [1:0]  cfg_value_count = 2'h1, cfg_sim_mode = 2'h0, values_shown;
  logic [2:0]  cfg_slot0_src = 3'h1, cfg_slot1_src = 3'h4;
  logic [2:0]  cfg_slot2_src = 3'h6, cfg_level_unit = 3'h4, fault_message;
  logic [2:0]  slot0_src, slot1_src, slot2_src, level_unit, tag_cursor;
  logic [6:0]  bar_percent;
  logic [3:0]  damping1, damping2;
  logic [63:0] tag_text;
  logic        backlight_on, simulation_indicator, fault_icon, menu_active;
  logic        scroll_arrow, temp_fahrenheit, direction_reversed;
  logic        seen_lo, seen_hi;
  int          err_count = 0, checks_done = 0, cyc = 0, n;

  ldm_display_ctrl #(.SIM_TIMEOUT(200), .MENU_IDLE(100))
    ldm_display_ctrl_i (.*);
  ldm_operator_model ldm_operator_model_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .store_req(store_req), .key_raw(key_raw),
    .magnet_raw(magnet_raw), .store_done(store_done));

  always #2.5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic key(input int k, input bit m = 1'b0);
    ldm_operator_model_i.press(k, m);
  endtask : key

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // The whole run needs about 600 cycles; the ceiling leaves wide margin.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle();
    chk(values_shown, 2'h1);
    chk({bar_percent, backlight_on}, {7'h32, 1'b1});
    chk({slot0_src, slot1_src, slot2_src}, {3'h1, 3'h4, 3'h6});
    chk({level_unit, temp_fahrenheit}, {3'h4, 1'b1});
    chk({damping1, damping2}, {4'hB, 4'h0});
    chk({min_upper, max_upper, min_temp}, {16'h0100, 16'h0100, 16'h0019});
    chk({min_lower, max_lower, max_temp}, {16'h0080, 16'h0080, 16'h0019});
    @(posedge clk_sys) measured_ua <= 16'h0BB8;
    settle();
    chk(backlight_on, 1'b0);
    @(posedge clk_sys) measured_ua <= 16'h4E20;
    settle();
    chk(bar_percent, 7'h64);
    for (int i = 0; i < 3; i++) begin
      key(ldm_pkg::KEY_DOWN, i[0]);
      chk(values_shown, (i == 2) ? 2'h1 : 2'(i + 2));
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys) error_flags <= 6'(1 << i);
      cfg_alarm_high <= i[0];
      settle();
      chk({fault_icon, fault_message}, {1'b1, 3'(i + 1)});
      chk(loop_ua, i[0] ? ldm_pkg::UA_21M5 : ldm_pkg::UA_3M6);
    end
    @(posedge clk_sys) error_flags <= 6'h00;
    key(ldm_pkg::KEY_DOWN);
    key(ldm_pkg::KEY_OK);
    chk({menu_active, scroll_arrow}, 2'h3);
    @(posedge clk_sys) cfg_set_4ma_point <= 1'b1;
    @(posedge clk_sys) cfg_set_4ma_point <= 1'b0;
    float_position <= 16'h0BB8;
    @(posedge clk_sys) cfg_set_20ma_point <= 1'b1;
    @(posedge clk_sys) cfg_set_20ma_point <= 1'b0;
    settle();
    chk({point_4ma, point_20ma}, {16'h03E8, 16'h0BB8});
    chk(direction_reversed, 1'b1);
    key(ldm_pkg::KEY_OK);
    key(ldm_pkg::KEY_OK);
    chk({menu_active, tag_cursor}, {1'b1, 3'h1});
    key(ldm_pkg::KEY_UP);
    chk(tag_text, 64'h2020202020202120);
    key(ldm_pkg::KEY_BACK);
    chk({menu_active, tag_cursor}, {1'b1, 3'h0});
    key(ldm_pkg::KEY_BACK);
    chk(menu_active, 1'b1);
    key(ldm_pkg::KEY_BACK);
    chk({store_req, loop_ua}, {1'b1, ldm_pkg::UA_12MA});
    for (n = 0; menu_active === 1'b1 && n < 100; n++) @(negedge clk_sys);
    settle();
    chk({menu_active, values_shown}, {1'b0, 2'h1});
    chk(loop_ua, ldm_pkg::UA_20MA);
    key(ldm_pkg::KEY_OK);
    cfg_sim_mode <= ldm_pkg::LDM_SIM_FIXED;
    settle();
    chk(simulation_indicator, 1'b0);
    key(ldm_pkg::KEY_BACK);
    chk({simulation_indicator, loop_ua}, {1'b1, 16'h1F40});
    key(ldm_pkg::KEY_OK);
    chk({simulation_indicator, menu_active}, 2'h1);
    key(ldm_pkg::KEY_BACK);
    for (n = 0; simulation_indicator === 1'b1 && n < 300; n++)
      @(negedge clk_sys);
    chk(n >= 180 && n <= 205, 1'b1);
    key(ldm_pkg::KEY_OK);
    cfg_sim_mode <= ldm_pkg::LDM_SIM_ALT;
    for (n = 0; menu_active === 1'b1 && n < 200; n++) @(negedge clk_sys);
    chk(n >= 80 && n <= 100, 1'b1);
    seen_lo = 1'b0;
    seen_hi = 1'b0;
    repeat (40) begin
      @(negedge clk_sys);
      seen_lo |= (loop_ua === 16'h1F40);
      seen_hi |= (loop_ua === 16'h3A98);
    end
    chk({seen_lo, seen_hi}, 2'h3);
    finish_test();
  end
endmodule : ldm_display_ctrl_bench

// [bench/ldm_operator_model.sv]
// Operator at the keypad and the flash store acknowledge.
// Assumes the controller samples keys with its own synchronisers.
`timescale 1ns/100ps
module ldm_operator_model (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       store_req,
  output logic      [3:0] key_raw,
  output logic      [3:0] magnet_raw,
  output logic            store_done
);
  // ==========================================================================
  // Keys and store handshake
  // ==========================================================================
  logic [4:0] busy_cnt;

  initial begin
    key_raw    = 4'h0;
    magnet_raw = 4'h0;
  end

  // Held for six cycles so the three-stage synchroniser sees a stable level.
  task automatic press(input int k, input bit m);
    @(posedge clk_sys);
    if (m) magnet_raw[k] <= 1'b1;
    else key_raw[k] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    key_raw    <= 4'h0;
    magnet_raw <= 4'h0;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : press

  // The flash is deliberately slow, so the 12 mA hold can be seen.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt   <= 5'h00;
      store_done <= 1'b0;
    end else if (!store_req) begin
      busy_cnt   <= 5'h00;
      store_done <= 1'b0;
    end else if (busy_cnt == 5'h14) begin
      store_done <= 1'b1;
    end else begin
      busy_cnt <= busy_cnt + 5'h01;
    end
  end
endmodule : ldm_operator_model

// [hdl/ldm_display_ctrl.sv]
// Display and menu controller: views, simulation, settings, loop current.
// Assumes measured values arrive from the same clock domain.
`timescale 1ns/100ps
// Behaviour
// - Backlight off below 4 mA.
// - Down key rotates one, two, three values.
// - Bar graph is current percent of span.
// - Simulation starts on leaving the menu.
// - Indicator shown; confirm or timeout ends simulation.
// - Simulated current overrides measured value.
// - Six error flags give fault icon, message.
// - Confirm in value view opens menu.
// - Leaving menu commits changed settings to storage.
// - Loop forced to 12 mA while storing.
// - Menu exits after two idle minutes.
// - Scroll arrow when items exceed screen.
// - Eight-character label; confirm, arrows, back edit.
// - Three slots each choose a value source.
// - Menu return restores configured count; start shows one value.
// - Stored backlight enable setting.
// - Level and temperature unit selection.
// - Damping zero or power-of-two code.
// - Span under 5 mm reverses direction.
// - Alarm current 3.6 or 21.5 mA.
// - Min/max track, cleared at restart.
// - Simulation off, fixed or alternating with cycle.
module ldm_display_ctrl #(
  parameter longint      SIM_TIMEOUT = ldm_pkg::SIM_TIMEOUT_CYC,
  parameter longint      MENU_IDLE   = ldm_pkg::MENU_IDLE_CYC,
  parameter int unsigned MENU_ITEMS  = 5,
  parameter int unsigned SCREEN_ROWS = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [3:0]  key_raw,
  input  wire logic [3:0]  magnet_raw,
  input  wire logic [15:0] measured_ua,
  input  wire logic [15:0] upper_float_level,
  input  wire logic [15:0] lower_float_level,
  input  wire logic [15:0] temperature_value,
  input  wire logic [15:0] float_position,
  input  wire logic [5:0]  error_flags,
  input  wire logic [1:0]  cfg_value_count,
  input  wire logic [2:0]  cfg_slot0_src,
  input  wire logic [2:0]  cfg_slot1_src,
  input  wire logic [2:0]  cfg_slot2_src,
  input  wire logic        cfg_backlight_en,
  input  wire logic [2:0]  cfg_level_unit,
  input  wire logic        cfg_temp_fahrenheit,
  input  wire logic [3:0]  cfg_damping1,
  input  wire logic [3:0]  cfg_damping2,
  input  wire logic        cfg_alarm_high,
  input  wire logic [1:0]  cfg_sim_mode,
  input  wire logic [15:0] cfg_sim_low_ua,
  input  wire logic [15:0] cfg_sim_high_ua,
  input  wire logic [31:0] cfg_sim_cycle,
  input  wire logic        cfg_set_4ma_point,
  input  wire logic        cfg_set_20ma_point,
  input  wire logic        store_done,
  output logic [15:0]      loop_ua,
  output logic [6:0]       bar_percent,
  output logic             backlight_on,
  output logic             simulation_indicator,
  output logic             fault_icon,
  output logic [2:0]       fault_message,
  output logic             menu_active,
  output logic             scroll_arrow,
  output logic [1:0]       values_shown,
  output logic [2:0]       slot0_src,
  output logic [2:0]       slot1_src,
  output logic [2:0]       slot2_src,
  output logic [2:0]       level_unit,
  output logic             temp_fahrenheit,
  output logic [3:0]       damping1,
  output logic [3:0]       damping2,
  output logic [15:0]      point_4ma,
  output logic [15:0]      point_20ma,
  output logic             direction_reversed,
  output logic [2:0]       tag_cursor,
  output logic [63:0]      tag_text,
  output logic             store_req,
  output logic [15:0]      min_upper,
  output logic [15:0]      max_upper,
  output logic [15:0]      min_lower,
  output logic [15:0]      max_lower,
  output logic [15:0]      min_temp,
  output logic [15:0]      max_temp
);
  initial begin
    if (MENU_ITEMS < 1 || SCREEN_ROWS < 1 || MENU_ITEMS > 15) begin
      $error("Menu size parameters out of range.");
    end
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    LDM_VIEW, LDM_MENU, LDM_TAG_EDIT, LDM_STORE
  } ldm_mode_e;

  typedef struct packed {
    ldm_mode_e   mode;
    logic [1:0]  shown;
    logic        sim_armed;
    logic        sim_run;
    logic        sim_high;
    logic [31:0] sim_cnt;
    logic [39:0] timeout_cnt;
    logic [39:0] idle_cnt;
    logic [3:0]  item;
    logic [3:0]  top;
    logic [2:0]  cursor;
    logic [63:0] tag;
    logic        dirty;
    logic [15:0] hold_ua;
    logic [4:0]  store_cnt;
    logic [15:0] p4;
    logic [15:0] p20;
    logic        rev;
    logic [15:0] loop;
    logic [6:0]  bar;
    logic [15:0] mn_u, mx_u, mn_l, mx_l, mn_t, mx_t;
  } ldm_state_s;

  ldm_state_s  state_reg;
  ldm_state_s  state_next;
  logic [3:0]  press;

  ldm_key_sync #(.N(4)) u_keys (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .key_raw    (key_raw),
    .magnet_raw (magnet_raw),
    .press      (press)
  );

  function automatic logic [1:0] next_count(input logic [1:0] c);
    next_count = (c >= 2'h3) ? 2'h1 : 2'(c + 2'h1);
  endfunction : next_count

  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    abs_diff = (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction : abs_diff

  function automatic logic [6:0] percent(input logic [15:0] ua);
    logic [31:0] t;
    t = 32'h0;
    if (ua <= ldm_pkg::UA_4MA) percent = 7'h00;
    else if (ua >= ldm_pkg::UA_20MA) percent = 7'h64;
    else begin
      t = 32'(ua - ldm_pkg::UA_4MA) * 32'd100 / 32'(ldm_pkg::UA_SPAN);
      percent = t[6:0];
    end
  endfunction : percent

  logic [15:0] loop_src;
  logic        any_key;
  logic        fault;

  assign any_key = press != 4'h0;
  assign fault   = error_flags != 6'h00;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    loop_src   = measured_ua;

    // Min and max start from the first sample after restart.
    if (upper_float_level < state_reg.mn_u) state_next.mn_u = upper_float_level;
    if (upper_float_level > state_reg.mx_u) state_next.mx_u = upper_float_level;
    if (lower_float_level < state_reg.mn_l) state_next.mn_l = lower_float_level;
    if (lower_float_level > state_reg.mx_l) state_next.mx_l = lower_float_level;
    if (temperature_value < state_reg.mn_t) state_next.mn_t = temperature_value;
    if (temperature_value > state_reg.mx_t) state_next.mx_t = temperature_value;

    case (state_reg.mode)
      LDM_VIEW: begin
        if (press[ldm_pkg::KEY_OK]) begin
          state_next.mode     = LDM_MENU;
          state_next.sim_run  = 1'b0;
          state_next.idle_cnt = '0;
          state_next.item     = '0;
          state_next.top      = '0;
        end else if (press[ldm_pkg::KEY_DOWN]) begin
          state_next.shown = next_count(state_reg.shown);
        end
      end
      LDM_MENU, LDM_TAG_EDIT: begin
        if (any_key) state_next.idle_cnt = '0;
        else state_next.idle_cnt = 40'(state_reg.idle_cnt + 40'h1);
        if (cfg_sim_mode != 2'(ldm_pkg::LDM_SIM_OFF))
          state_next.sim_armed = 1'b1;
        // Accepting a point that collapses the span flips direction.
        if (cfg_set_4ma_point) begin
          state_next.p4    = float_position;
          state_next.dirty = 1'b1;
          if (abs_diff(float_position, state_reg.p20) < ldm_pkg::MIN_SPAN_UM)
            state_next.rev = ~state_reg.rev;
        end else if (cfg_set_20ma_point) begin
          state_next.p20   = float_position;
          state_next.dirty = 1'b1;
          if (abs_diff(float_position, state_reg.p4) < ldm_pkg::MIN_SPAN_UM)
            state_next.rev = ~state_reg.rev;
        end
        if (state_reg.mode == LDM_TAG_EDIT) begin
          if (press[ldm_pkg::KEY_OK]) begin
            state_next.cursor = 3'(state_reg.cursor + 3'h1);
          end else if (press[ldm_pkg::KEY_UP]) begin
            state_next.tag[state_reg.cursor*8 +: 8] =
              8'(state_reg.tag[state_reg.cursor*8 +: 8] + 8'h01);
            state_next.dirty = 1'b1;
          end else if (press[ldm_pkg::KEY_DOWN]) begin
            state_next.tag[state_reg.cursor*8 +: 8] =
              8'(state_reg.tag[state_reg.cursor*8 +: 8] - 8'h01);
            state_next.dirty = 1'b1;
          end else if (press[ldm_pkg::KEY_BACK]) begin
            if (state_reg.cursor == 3'h0) state_next.mode = LDM_MENU;
            else state_next.cursor = 3'(state_reg.cursor - 3'h1);
          end
        end else begin
          if (press[ldm_pkg::KEY_UP] && state_reg.item != 4'h0) begin
            state_next.item = 4'(state_reg.item - 4'h1);
            if (state_reg.item == state_reg.top)
              state_next.top = 4'(state_reg.top - 4'h1);
          end else if (press[ldm_pkg::KEY_DOWN] &&
                       32'(state_reg.item) < MENU_ITEMS - 1) begin
            state_next.item = 4'(state_reg.item + 4'h1);
            if (32'(state_reg.item) >= 32'(state_reg.top) + SCREEN_ROWS - 1)
              state_next.top = 4'(state_reg.top + 4'h1);
          end else if (press[ldm_pkg::KEY_OK]) begin
            state_next.mode   = LDM_TAG_EDIT;
            state_next.cursor = '0;
          end
        end
        if ((state_reg.mode == LDM_MENU && press[ldm_pkg::KEY_BACK]) ||
            state_reg.idle_cnt >= 40'(MENU_IDLE - 1)) begin
          state_next.shown = cfg_value_count;
          if (state_reg.dirty) begin
            state_next.mode      = LDM_STORE;
            state_next.hold_ua   = state_reg.loop;
            state_next.store_cnt = '0;
          end else begin
            state_next.mode = LDM_VIEW;
            state_next.sim_run = state_reg.sim_armed;
          end
          state_next.sim_armed   = 1'b0;
          state_next.timeout_cnt = '0;
          state_next.sim_cnt     = '0;
          state_next.sim_high    = 1'b0;
        end
      end
      LDM_STORE: begin
        if (state_reg.store_cnt != 5'h1F)
          state_next.store_cnt = 5'(state_reg.store_cnt + 5'h1);
        if (store_done &&
            32'(state_reg.store_cnt) >= ldm_pkg::STORE_HOLD_CYC) begin
          state_next.mode    = LDM_VIEW;
          state_next.dirty   = 1'b0;
          state_next.sim_run = cfg_sim_mode != 2'(ldm_pkg::LDM_SIM_OFF);
        end
      end
      default: state_next.mode = LDM_VIEW;
    endcase

    if (state_reg.sim_run && state_reg.mode == LDM_VIEW) begin
      state_next.timeout_cnt = 40'(state_reg.timeout_cnt + 40'h1);
      if (state_reg.timeout_cnt >= 40'(SIM_TIMEOUT - 1))
        state_next.sim_run = 1'b0;
      if (cfg_sim_mode == 2'(ldm_pkg::LDM_SIM_ALT)) begin
        if (state_reg.sim_cnt >= cfg_sim_cycle) begin
          state_next.sim_cnt  = '0;
          state_next.sim_high = ~state_reg.sim_high;
        end else begin
          state_next.sim_cnt = 32'(state_reg.sim_cnt + 32'h1);
        end
      end
    end

    // Storage takes precedence; alarm beats simulation and measurement.
    if (state_reg.mode == LDM_STORE) loop_src = ldm_pkg::UA_12MA;
    else if (fault)
      loop_src = cfg_alarm_high ? ldm_pkg::UA_21M5 : ldm_pkg::UA_3M6;
    else if (state_reg.sim_run)
      loop_src = state_reg.sim_high ? cfg_sim_high_ua : cfg_sim_low_ua;
    state_next.loop = loop_src;
    state_next.bar  = percent(loop_src);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= '0;
      state_reg.mode <= LDM_VIEW;
      state_reg.shown <= 2'h1;
      state_reg.loop <= ldm_pkg::UA_4MA;
      state_reg.mn_u <= 16'hFFFF;
      state_reg.mn_l <= 16'hFFFF;
      state_reg.mn_t <= 16'hFFFF;
      state_reg.p20  <= 16'hFFFF;
      state_reg.tag  <= {8{8'h20}};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic [2:0] err_code;
  always_comb begin
    err_code = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (error_flags[i]) err_code = 3'(i + 1);
    end
  end

  assign loop_ua       = state_reg.loop;
  assign bar_percent   = state_reg.bar;
  assign backlight_on  = cfg_backlight_en &&
                         state_reg.loop >= ldm_pkg::UA_4MA;
  assign simulation_indicator = state_reg.sim_run;
  assign fault_icon    = fault;
  assign fault_message = err_code;
  assign menu_active   = state_reg.mode != LDM_VIEW;
  assign scroll_arrow  = state_reg.mode == LDM_MENU &&
                         32'(state_reg.top) + SCREEN_ROWS < MENU_ITEMS;
  assign values_shown  = state_reg.shown;
  assign slot0_src     = cfg_slot0_src > ldm_pkg::SRC_MAX ? 3'h0
                                                          : cfg_slot0_src;
  assign slot1_src     = cfg_slot1_src > ldm_pkg::SRC_MAX ? 3'h0 : cfg_slot1_src;
  assign slot2_src     = cfg_slot2_src > ldm_pkg::SRC_MAX ? 3'h0 : cfg_slot2_src;
  assign level_unit    = cfg_level_unit > ldm_pkg::LUNIT_MAX ? 3'h0
                                                           : cfg_level_unit;
  assign temp_fahrenheit = cfg_temp_fahrenheit;
  assign damping1      = cfg_damping1 > ldm_pkg::DAMP_MAX ? ldm_pkg::DAMP_MAX
                                                        : cfg_damping1;
  assign damping2      = cfg_damping2 > ldm_pkg::DAMP_MAX ? ldm_pkg::DAMP_MAX
                                                        : cfg_damping2;
  assign point_4ma     = state_reg.p4;
  assign point_20ma    = state_reg.p20;
  assign direction_reversed = state_reg.rev;
  assign tag_cursor    = state_reg.cursor;
  assign tag_text      = state_reg.tag;
  assign store_req     = state_reg.mode == LDM_STORE;
  assign min_upper     = state_reg.mn_u;
  assign max_upper     = state_reg.mx_u;
  assign min_lower     = state_reg.mn_l;
  assign max_lower     = state_reg.mx_l;
  assign min_temp      = state_reg.mn_t;
  assign max_temp      = state_reg.mx_t;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_ok_in_view;
    state_reg.mode == LDM_VIEW && press[ldm_pkg::KEY_OK];
  endsequence

  a_ok_opens_menu: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_ok_in_view |=> menu_active && !simulation_indicator)
    else $error("Confirm in value view did not open the menu.");
  a_backlight_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    loop_ua < ldm_pkg::UA_4MA |-> !backlight_on)
    else $error("Backlight lit below 4 mA.");
  a_store_12ma: assert property (@(posedge clk_sys) disable iff (!reset_n)
    store_req ##1 store_req |-> loop_ua == ldm_pkg::UA_12MA)
    else $error("Loop not at 12 mA during storage.");
  a_down_rotates: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg.mode == LDM_VIEW && press == 4'h4) |=>
      values_shown == next_count($past(values_shown)))
    else $error("Down key did not rotate the value count.");
  a_sim_no_menu: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(simulation_indicator) |-> $past(menu_active))
    else $error("Simulation started outside menu exit.");
  a_bar_full: assert property (@(posedge clk_sys) disable iff (!reset_n)
    loop_ua >= ldm_pkg::UA_20MA |-> bar_percent == 7'h64)
    else $error("Bar graph not full at 20 mA.");
  a_fault_alarm: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fault && !store_req |=>
      loop_ua == ($past(cfg_alarm_high) ? ldm_pkg::UA_21M5 : ldm_pkg::UA_3M6))
    else $error("Alarm current not driven during fault.");
  a_tag_back: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg.mode == LDM_TAG_EDIT && press == 4'h1 && tag_cursor != 3'h0)
      |=> state_reg.mode == LDM_TAG_EDIT)
    else $error("Back left label edit off first character.");

endmodule : ldm_display_ctrl

// [hdl/ldm_key_sync.sv]
// Merges membrane keys and magnetic sensors into one press pulse per key.
// Assumes raw asynchronous inputs; three stages, change on stage 2/3 agree.
`timescale 1ns/100ps
module ldm_key_sync #(
  parameter int unsigned N = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] key_raw,
  input  wire logic [N-1:0] magnet_raw,
  output logic      [N-1:0] press
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] level;
    logic [N-1:0] press;
  } ldm_sync_s;

  ldm_sync_s state_reg;
  ldm_sync_s state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.s1    = key_raw | magnet_raw;
    state_next.s2    = state_reg.s1;
    state_next.s3    = state_reg.s2;
    state_next.press = '0;
    for (int i = 0; i < N; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.level[i] = state_reg.s3[i];
        state_next.press[i] = state_reg.s3[i] & ~state_reg.level[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign press = state_reg.press;

  a_press_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (press != '0) |=> (press & $past(press)) == '0)
    else $error("Press pulse lasted more than one cycle.");

endmodule : ldm_key_sync

// [hdl/ldm_pkg.sv]
// Package for the level display and menu controller.
// Assumes a 200 MHz system clock; times are converted to cycles here.
package ldm_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ         = 200;
  localparam longint      SIM_TIMEOUT_MIN = 5;
  localparam longint      MENU_IDLE_MIN   = 2;
  localparam longint      SIM_TIMEOUT_CYC = SIM_TIMEOUT_MIN * 64'd60
                                            * 64'd1000000 * CLK_MHZ;
  localparam longint      MENU_IDLE_CYC   = MENU_IDLE_MIN * 64'd60
                                            * 64'd1000000 * CLK_MHZ;
  localparam int unsigned STORE_HOLD_CYC  = 16;

  // ==========================================================================
  // Loop current in microamps, minimum span in micrometres
  // ==========================================================================
  localparam logic [15:0] UA_4MA   = 16'h0FA0;
  localparam logic [15:0] UA_12MA  = 16'h2EE0;
  localparam logic [15:0] UA_20MA  = 16'h4E20;
  localparam logic [15:0] UA_3M6   = 16'h0E10;
  localparam logic [15:0] UA_21M5  = 16'h53FC;
  localparam logic [15:0] UA_SPAN  = 16'h3E80;
  localparam logic [15:0] MIN_SPAN_UM = 16'h1388;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam int unsigned KEY_BACK = 0;
  localparam int unsigned KEY_UP   = 1;
  localparam int unsigned KEY_DOWN = 2;
  localparam int unsigned KEY_OK   = 3;
  localparam int unsigned TAG_LEN  = 8;
  localparam logic [3:0]  DAMP_MAX = 4'hB;
  localparam logic [2:0]  SRC_MAX  = 3'h6;
  localparam logic [2:0]  LUNIT_MAX = 3'h4;

  typedef enum logic [1:0] {
    LDM_SIM_OFF, LDM_SIM_FIXED, LDM_SIM_ALT
  } ldm_sim_mode_e;

  typedef enum logic [2:0] {
    LDM_SRC_NONE, LDM_SRC_UPPER, LDM_SRC_LOWER, LDM_SRC_TEMP,
    LDM_SRC_DIFF, LDM_SRC_CURRENT, LDM_SRC_PERCENT
  } ldm_src_e;

endpackage : ldm_pkg
